// [hdl/ccr_pkg.sv]
package ccr_pkg;

  // Video width and component count
  localparam int CCR_DW   = 10;
  localparam int CCR_NCMP = 3;

  // Register byte offsets
  localparam logic [7:0] CCR_REG_CTRL   = 8'h00;
  localparam logic [7:0] CCR_REG_SET    = 8'h04;
  localparam logic [7:0] CCR_REG_GAIN   = 8'h08;
  localparam logic [7:0] CCR_REG_LIFT   = 8'h0C;
  localparam logic [7:0] CCR_REG_GAMMA  = 8'h10;
  localparam logic [7:0] CCR_REG_ENABLE = 8'h14;
  localparam logic [7:0] CCR_REG_CMD    = 8'h18;
  localparam logic [7:0] CCR_REG_STATUS = 8'h1C;

  // Control field positions
  localparam int CCR_CTRL_SEL_LSB  = 0;
  localparam int CCR_CTRL_LINK_LSB = 2;
  localparam int CCR_CTRL_WB_BIT   = 5;
  localparam int CCR_CMD_UNITY_BIT = 0;

  // Accepted ranges of the adjustments
  localparam logic signed [15:0] CCR_GAIN_MIN  = 16'sh0000;
  localparam logic signed [15:0] CCR_GAIN_MAX  = 16'sh00C8;
  localparam logic signed [15:0] CCR_LIFT_MIN  = -16'sh0028;
  localparam logic signed [15:0] CCR_LIFT_MAX  = 16'sh0064;
  localparam logic signed [15:0] CCR_GAMMA_MIN = -16'sh0064;
  localparam logic signed [15:0] CCR_GAMMA_MAX = 16'sh0064;
  localparam logic signed [15:0] CCR_WHITE_MIN = -16'sh0028;
  localparam logic signed [15:0] CCR_WHITE_MAX = 16'sh012C;

  // Nominal values
  localparam logic [7:0]        CCR_GAIN_NOM  = 8'h64;
  localparam logic signed [7:0] CCR_LIFT_NOM  = 8'sh00;
  localparam logic signed [7:0] CCR_GAMMA_NOM = 8'sh00;

  // Arithmetic constants, fixed point
  localparam logic signed [27:0] CCR_VMAX = 28'sh000_03FF;
  localparam logic signed [27:0] CCR_BLK  = 28'sh000_0040;
  localparam logic signed [27:0] CCR_CMID = 28'sh000_0200;
  localparam logic signed [27:0] CCR_K_RV = 28'sh000_064D;
  localparam logic signed [27:0] CCR_K_GU = 28'sh000_00C0;
  localparam logic signed [27:0] CCR_K_GV = 28'sh000_01DF;
  localparam logic signed [27:0] CCR_K_BU = 28'sh000_076C;
  localparam logic signed [27:0] CCR_K_YR = 28'sh000_00DA;
  localparam logic signed [27:0] CCR_K_YG = 28'sh000_02DC;
  localparam logic signed [27:0] CCR_K_YB = 28'sh000_004A;
  localparam logic signed [27:0] CCR_K_CB = 28'sh000_0228;
  localparam logic signed [27:0] CCR_K_CR = 28'sh000_028A;
  localparam logic signed [27:0] CCR_KPCT = 28'sh000_0029;
  localparam logic signed [27:0] CCR_KIRE = 28'sh000_0023;
  localparam int CCR_SH_COEF = 10;
  localparam int CCR_SH_PCT  = 12;
  localparam int CCR_SH_IRE  = 2;

  // Cycle counts
  localparam int         CCR_PIPE_LAT = 4;
  localparam logic [1:0] CCR_LOAD_CYC = 2'h2;

  typedef struct packed {
    logic                 en;
    logic [7:0]           gain;
    logic signed [7:0]    lift;
    logic signed [7:0]    gamma;
  } ccr_comp_t;

  typedef ccr_comp_t [CCR_NCMP-1:0] ccr_set_t;

  typedef struct packed {
    logic              sof;
    logic [CCR_DW-1:0] y;
    logic [CCR_DW-1:0] cb;
    logic [CCR_DW-1:0] cr;
  } ccr_pix_t;

  typedef logic [CCR_NCMP-1:0][CCR_DW-1:0] ccr_rgb_t;

  localparam ccr_comp_t CCR_COMP_NOM = '{en: 1'b0, gain: CCR_GAIN_NOM,
                                         lift: CCR_LIFT_NOM, gamma: CCR_GAMMA_NOM};

endpackage

// [hdl/ccr_set_mem.sv]
`timescale 1ns/1ns
module ccr_set_mem #(
  parameter int W  = 75,
  parameter int AW = 6
) (
  input  wire logic          clk,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [W-1:0]  a_wdata,
  output logic      [W-1:0]  a_rdata,
  input  wire logic [AW-1:0] b_addr,
  output logic      [W-1:0]  b_rdata
);

  logic [W-1:0] mem [2**AW];

  // Edit port, write and registered read
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
  end

  // Video port, registered read
  always_ff @(posedge clk) begin
    b_rdata <= mem[b_addr];
  end

endmodule

// [hdl/ccr_top.sv]
// Operation
// - Take Y Cb Cr, convert to RGB, correct, convert back to Y Cb Cr.
// - Red, green and blue each carry own lift, gain and gamma path.
// - Parameter sets are chosen by source and bus pairing.
// - Disabled component keeps adjustable values but passes at unity.
// - Gain 0..200 nom 100, lift -40..100 nom 0, gamma -100..100 nom 0.
// - Gain and lift also settable as black and white endpoints.
// - Out-of-range results clip at the limits, never wrap.
// - Lift is a constant offset; zero is black, 100 IRE is white.
// - Slope follows gain; zero gain gives constant output.
// - Gamma bends curve: down-concave positive, up-concave negative, straight zero.
// - Writes to the selected component also go to linked components.
// - Selecting another component clears all links.
// - Reset command restores nominal values on selected and linked components.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module ccr_top #(
  parameter int SRCW = 4,
  parameter int BUSW = 2
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire ccr_pkg::ccr_pix_t      vid_in,
  input  wire logic                   vid_in_valid,
  input  wire logic [SRCW-1:0]        vid_src,
  input  wire logic [BUSW-1:0]        vid_bus,
  output ccr_pkg::ccr_pix_t           vid_out,
  output logic                        vid_out_valid
);

  localparam int SETW = SRCW + BUSW;
  localparam int NC   = ccr_pkg::CCR_NCMP;

  // Arithmetic helpers
  function automatic logic [9:0] clip10(input logic signed [27:0] v);
    if (v < 0) begin
      return '0;
    end else if (v > ccr_pkg::CCR_VMAX) begin
      return ccr_pkg::CCR_VMAX[9:0];
    end
    return v[9:0];
  endfunction

  function automatic logic signed [15:0] clampv(input logic signed [15:0] v,
                                                input logic signed [15:0] lo,
                                                input logic signed [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic ccr_pkg::ccr_rgb_t ycc_to_rgb(input ccr_pkg::ccr_pix_t p);
    logic signed [27:0] y;
    logic signed [27:0] u;
    logic signed [27:0] v;
    ccr_pkg::ccr_rgb_t  o;
    y = 28'(p.y);
    u = 28'(p.cb) - ccr_pkg::CCR_CMID;
    v = 28'(p.cr) - ccr_pkg::CCR_CMID;
    o[0] = clip10(y + ((ccr_pkg::CCR_K_RV * v) >>> ccr_pkg::CCR_SH_COEF));
    o[1] = clip10(y - ((ccr_pkg::CCR_K_GU * u + ccr_pkg::CCR_K_GV * v)
                       >>> ccr_pkg::CCR_SH_COEF));
    o[2] = clip10(y + ((ccr_pkg::CCR_K_BU * u) >>> ccr_pkg::CCR_SH_COEF));
    return o;
  endfunction

  function automatic ccr_pkg::ccr_pix_t rgb_to_ycc(input logic [9:0] r,
                                                   input logic [9:0] g,
                                                   input logic [9:0] b,
                                                   input logic sof);
    logic signed [27:0] yv;
    ccr_pkg::ccr_pix_t  o;
    yv = (ccr_pkg::CCR_K_YR * 28'(r) + ccr_pkg::CCR_K_YG * 28'(g)
          + ccr_pkg::CCR_K_YB * 28'(b)) >>> ccr_pkg::CCR_SH_COEF;
    o.sof = sof;
    o.y   = clip10(yv);
    o.cb  = clip10(ccr_pkg::CCR_CMID + ((ccr_pkg::CCR_K_CB * ($signed(28'(b)) - yv))
                   >>> ccr_pkg::CCR_SH_COEF));
    o.cr  = clip10(ccr_pkg::CCR_CMID + ((ccr_pkg::CCR_K_CR * ($signed(28'(r)) - yv))
                   >>> ccr_pkg::CCR_SH_COEF));
    return o;
  endfunction

  // Curvature peaks mid-scale and vanishes at both ends
  function automatic logic [9:0] gamma_fn(input logic [9:0] x,
                                          input logic signed [7:0] gm);
    logic signed [27:0] xs;
    logic signed [27:0] t;
    xs = 28'(x);
    t  = (xs * (ccr_pkg::CCR_VMAX - xs)) >>> ccr_pkg::CCR_SH_COEF;
    return clip10(xs + ((t * 28'(gm) * ccr_pkg::CCR_KPCT) >>> ccr_pkg::CCR_SH_PCT));
  endfunction

  // Slope from gain about black, offset from lift, clipped
  function automatic logic [9:0] gain_fn(input logic [9:0] x,
                                         input logic [7:0] gn,
                                         input logic signed [7:0] lf);
    logic signed [27:0] v;
    logic signed [27:0] gs;
    v  = 28'(x) - ccr_pkg::CCR_BLK;
    gs = 28'(gn);
    return clip10(ccr_pkg::CCR_BLK
                  + ((v * gs * ccr_pkg::CCR_KPCT) >>> ccr_pkg::CCR_SH_PCT)
                  + ((28'(lf) * ccr_pkg::CCR_KIRE) >>> ccr_pkg::CCR_SH_IRE));
  endfunction

  function automatic logic signed [15:0] white_of(input ccr_pkg::ccr_comp_t c);
    return $signed(16'(c.gain)) + 16'(c.lift);
  endfunction

  // Control and edit state
  logic [1:0]          sel;
  logic [NC-1:0]       link;
  logic                wb;
  logic [SETW-1:0]     edit_set;
  ccr_pkg::ccr_comp_t  ed [NC];
  ccr_pkg::ccr_comp_t  ed_sel;
  ccr_pkg::ccr_set_t   ed_set;
  logic [NC-1:0]       hit;
  logic                dirty;
  logic [1:0]          load_cnt;
  logic                init_run;
  logic [SETW-1:0]     init_idx;
  logic                busy;
  logic signed [15:0]  wv;
  logic                wr_en;
  logic                wr_ctrl;
  logic                wr_set;
  logic                wr_gain;
  logic                wr_lift;
  logic                wr_gamma;
  logic                wr_enable;
  logic                wr_unity;
  logic [31:0]         next_prdata;
  logic                mapped;

  // Memory ports
  logic                mem_we;
  logic [SETW-1:0]     mem_addr;
  ccr_pkg::ccr_set_t   mem_wdata;
  ccr_pkg::ccr_set_t   mem_rdata;
  ccr_pkg::ccr_set_t   rd_b;

  // Datapath state
  ccr_pkg::ccr_rgb_t   s1_rgb;
  logic                s1_v;
  logic                s1_sof;
  logic [SETW-1:0]     s1_idx;
  logic                s1_fs;
  logic                s2_v;
  logic                s2_sof;
  logic                s2_fs;
  logic [9:0]          s2_x [NC];
  logic                s3_v;
  logic                s3_sof;
  logic [9:0]          s3_x [NC];
  ccr_pkg::ccr_set_t   act2;
  ccr_pkg::ccr_set_t   act3;
  ccr_pkg::ccr_set_t   next_act2;
  ccr_pkg::ccr_set_t   next_act3;
  logic [SETW-1:0]     act_idx;

  // Checks share one clock and the reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Bus strobes and write value
  assign wr_en     = psel & penable & pready & pwrite;
  assign wr_ctrl   = wr_en & (paddr == ccr_pkg::CCR_REG_CTRL);
  assign wr_set    = wr_en & (paddr == ccr_pkg::CCR_REG_SET);
  assign wr_gain   = wr_en & (paddr == ccr_pkg::CCR_REG_GAIN);
  assign wr_lift   = wr_en & (paddr == ccr_pkg::CCR_REG_LIFT);
  assign wr_gamma  = wr_en & (paddr == ccr_pkg::CCR_REG_GAMMA);
  assign wr_enable = wr_en & (paddr == ccr_pkg::CCR_REG_ENABLE);
  assign wr_unity  = wr_en & (paddr == ccr_pkg::CCR_REG_CMD)
                     & pwdata[ccr_pkg::CCR_CMD_UNITY_BIT];
  assign wv        = pwdata[15:0];
  assign busy      = init_run | dirty | (load_cnt != 2'h0);
  assign mapped    = (paddr[1:0] == 2'h0) & (paddr <= ccr_pkg::CCR_REG_STATUS);
  assign ed_sel    = ed[sel];
  assign s1_fs     = s1_v & s1_sof;
  assign s2_fs     = s2_v & s2_sof;

  // Control register; a new selection drops all links
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel  <= 2'h0;
      link <= '0;
      wb   <= 1'b0;
    end else if (wr_ctrl) begin
      wb <= pwdata[ccr_pkg::CCR_CTRL_WB_BIT];
      if (pwdata[ccr_pkg::CCR_CTRL_SEL_LSB +: 2] < 2'(NC)) begin
        sel <= pwdata[ccr_pkg::CCR_CTRL_SEL_LSB +: 2];
      end
      if (pwdata[ccr_pkg::CCR_CTRL_SEL_LSB +: 2] != sel) begin
        link <= '0;
      end else begin
        link <= pwdata[ccr_pkg::CCR_CTRL_LINK_LSB +: NC];
      end
    end
  end

  // Edit set pointer, load sequencer and write-back
  always_ff @(posedge clk) begin
    if (!nrst) begin
      edit_set <= '0;
      load_cnt <= 2'h0;
      dirty    <= 1'b0;
      init_run <= 1'b1;
      init_idx <= '0;
    end else begin
      if (init_run) begin
        init_idx <= init_idx + 1'b1;
        init_run <= (init_idx != {SETW{1'b1}});
      end
      if (wr_set) begin
        edit_set <= pwdata[SETW-1:0];
        load_cnt <= ccr_pkg::CCR_LOAD_CYC;
      end else if (load_cnt != 2'h0) begin
        load_cnt <= load_cnt - 2'h1;
      end
      dirty <= wr_gain | wr_lift | wr_gamma | wr_enable | wr_unity;
    end
  end

  // Edit registers of each component
  for (genvar c = 0; c < NC; c++) begin : g_edit
    assign hit[c] = (sel == 2'(c)) | link[c];
    always_ff @(posedge clk) begin
      if (!nrst) begin
        ed[c] <= ccr_pkg::CCR_COMP_NOM;
      end else if (load_cnt == 2'h1) begin
        ed[c] <= mem_rdata[c];
      end else if (wr_unity && hit[c]) begin
        ed[c].gain  <= ccr_pkg::CCR_GAIN_NOM;
        ed[c].lift  <= ccr_pkg::CCR_LIFT_NOM;
        ed[c].gamma <= ccr_pkg::CCR_GAMMA_NOM;
      end else if (wr_gain && hit[c]) begin
        if (wb) begin
          ed[c].gain <= 8'(clampv(clampv(wv, ccr_pkg::CCR_WHITE_MIN,
                                         ccr_pkg::CCR_WHITE_MAX) - 16'(ed[c].lift),
                                  ccr_pkg::CCR_GAIN_MIN, ccr_pkg::CCR_GAIN_MAX));
        end else begin
          ed[c].gain <= 8'(clampv(wv, ccr_pkg::CCR_GAIN_MIN, ccr_pkg::CCR_GAIN_MAX));
        end
      end else if (wr_lift && hit[c]) begin
        ed[c].lift <= 8'(clampv(wv, ccr_pkg::CCR_LIFT_MIN, ccr_pkg::CCR_LIFT_MAX));
        if (wb) begin
          ed[c].gain <= 8'(clampv(white_of(ed[c]) - clampv(wv, ccr_pkg::CCR_LIFT_MIN,
                                  ccr_pkg::CCR_LIFT_MAX),
                                  ccr_pkg::CCR_GAIN_MIN, ccr_pkg::CCR_GAIN_MAX));
        end
      end else if (wr_gamma && hit[c]) begin
        ed[c].gamma <= 8'(clampv(wv, ccr_pkg::CCR_GAMMA_MIN, ccr_pkg::CCR_GAMMA_MAX));
      end else if (wr_enable) begin
        ed[c].en <= pwdata[c];
      end
    end
    assign ed_set[c] = ed[c];
  end

  // Memory port A: nominal sweep after reset, else write-back of the edit set
  assign mem_we    = init_run | dirty;
  assign mem_addr  = init_run ? init_idx : edit_set;
  assign mem_wdata = init_run ? {NC{ccr_pkg::CCR_COMP_NOM}} : ed_set;

  ccr_set_mem #(
    .W  ($bits(ccr_pkg::ccr_set_t)),
    .AW (SETW)
  ) u_mem (
    .clk     (clk),
    .a_we    (mem_we),
    .a_addr  (mem_addr),
    .a_wdata (mem_wdata),
    .a_rdata (mem_rdata),
    .b_addr  ({vid_bus, vid_src}),
    .b_rdata (rd_b)
  );

  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ccr_pkg::CCR_REG_CTRL: begin
        next_prdata[ccr_pkg::CCR_CTRL_SEL_LSB +: 2]   = sel;
        next_prdata[ccr_pkg::CCR_CTRL_LINK_LSB +: NC] = link;
        next_prdata[ccr_pkg::CCR_CTRL_WB_BIT]         = wb;
      end
      ccr_pkg::CCR_REG_SET:    next_prdata[SETW-1:0] = edit_set;
      ccr_pkg::CCR_REG_GAIN:   next_prdata = wb ? 32'(white_of(ed_sel)) : 32'(ed_sel.gain);
      ccr_pkg::CCR_REG_LIFT:   next_prdata = 32'(ed_sel.lift);
      ccr_pkg::CCR_REG_GAMMA:  next_prdata = 32'(ed_sel.gamma);
      ccr_pkg::CCR_REG_ENABLE: next_prdata[NC-1:0] = {ed[2].en, ed[1].en, ed[0].en};
      ccr_pkg::CCR_REG_STATUS: next_prdata[SETW:0] = {act_idx, busy};
      default:                 next_prdata = 32'h0000_0000;
    endcase
  end

  // APB answer, no wait state, held off while busy
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~pready & ~busy;
      pslverr <= psel & ~pready & ~busy & ~mapped;
      prdata  <= (psel & ~pready & ~busy & mapped) ? next_prdata : 32'h0000_0000;
    end
  end

  // Parameters switch only as a frame start passes each stage
  always_comb begin
    next_act2 = s1_fs ? rd_b : act2;
    next_act3 = s2_fs ? act2 : act3;
  end

  // Colour difference to RGB
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_rgb  <= '0;
      s1_v    <= 1'b0;
      s1_sof  <= 1'b0;
      s1_idx  <= '0;
      act2    <= {NC{ccr_pkg::CCR_COMP_NOM}};
      act3    <= {NC{ccr_pkg::CCR_COMP_NOM}};
      act_idx <= '0;
    end else begin
      s1_rgb  <= ycc_to_rgb(vid_in);
      s1_v    <= vid_in_valid;
      s1_sof  <= vid_in.sof;
      s1_idx  <= {vid_bus, vid_src};
      act2    <= next_act2;
      act3    <= next_act3;
      act_idx <= s1_fs ? s1_idx : act_idx;
    end
  end

  // Per component gamma, then gain and lift; bypass keeps stage count
  for (genvar c = 0; c < NC; c++) begin : g_comp
    always_ff @(posedge clk) begin
      if (!nrst) begin
        s2_x[c] <= '0;
        s3_x[c] <= '0;
      end else begin
        s2_x[c] <= next_act2[c].en ? gamma_fn(s1_rgb[c], next_act2[c].gamma)
                                   : s1_rgb[c];
        s3_x[c] <= next_act3[c].en ? gain_fn(s2_x[c], next_act3[c].gain,
                                             next_act3[c].lift)
                                   : s2_x[c];
      end
    end

    bypass_unity_a: assert property (s1_v && !next_act2[c].en |=>
                      s2_x[c] == $past(s1_rgb[c]))
      else $error("disabled component not passed at unity");
    zero_gain_a: assert property (s2_v && next_act3[c].en && next_act3[c].gain == 8'h00
                      && next_act3[c].lift == 8'sh00 |=> s3_x[c] == 10'h040)
      else $error("zero gain did not give black level");
  end

  // Valid and frame start alongside the data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s2_v          <= 1'b0;
      s2_sof        <= 1'b0;
      s3_v          <= 1'b0;
      s3_sof        <= 1'b0;
      vid_out_valid <= 1'b0;
      vid_out       <= '0;
    end else begin
      s2_v          <= s1_v;
      s2_sof        <= s1_sof;
      s3_v          <= s2_v;
      s3_sof        <= s2_sof;
      vid_out_valid <= s3_v;
      vid_out       <= rgb_to_ycc(s3_x[0], s3_x[1], s3_x[2], s3_sof);
    end
  end

  // Checks
  pipe_latency_a: assert property (vid_in_valid |-> ##4 vid_out_valid)
    else $error("output valid not four cycles after input");
  sof_carry_a: assert property (vid_in_valid && vid_in.sof |-> ##4 vid_out.sof)
    else $error("frame start lost in pipeline");
  frame_switch_a: assert property (!$stable(act2) |-> $past(s1_fs))
    else $error("parameters changed away from frame start");
  sel_unlink_a: assert property (wr_ctrl && pwdata[1:0] != sel |=> link == '0)
    else $error("links kept after selection change");
  link_copy_a: assert property (wr_gain && !wb && sel == 2'h0 && link[1]
                    |=> ed[1].gain == ed[0].gain)
    else $error("linked component missed gain write");
  unity_reset_a: assert property (wr_unity |=> ed_sel.gain == ccr_pkg::CCR_GAIN_NOM
                    && ed_sel.lift == 8'sh00 && ed_sel.gamma == 8'sh00)
    else $error("reset did not restore nominal values");
  gain_range_a: assert property (ed_sel.gain <= 8'hC8)
    else $error("gain beyond range");
  lift_range_a: assert property (ed_sel.lift >= -8'sh28 && ed_sel.lift <= 8'sh64)
    else $error("lift beyond range");
  bus_answer_a: assert property (psel && !penable && !pready && !busy |=> pready)
    else $error("setup not answered in one cycle");

  unity_cmd_c: cover property (wr_unity && link != '0);
  wb_write_c: cover property (wr_lift && wb);
  frame_on_c: cover property (s1_fs && rd_b[0].en);
  set_load_c: cover property (wr_set ##[1:8] load_cnt == 2'h1);

endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic              clk;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  ccr_pkg::ccr_pix_t vid_in;
  logic              vid_in_valid;
  logic [3:0]        vid_src;
  logic [1:0]        vid_bus;
  ccr_pkg::ccr_pix_t vid_out;
  logic              vid_out_valid;
  int                errors;
  int                samples_checked;
  logic [31:0]       rd;
  logic              er;
  int                i;
  // Clamp table: register, written value, read-back value
  logic [7:0]        t_a [5] = '{8'h08, 8'h08, 8'h0C, 8'h0C, 8'h10};
  logic [31:0]       t_w [5] = '{32'h0000_012C, 32'h0000_FFFB, 32'h0000_FF9C,
                                 32'h0000_0096, 32'h0000_FED4};
  logic [31:0]       t_e [5] = '{32'h0000_00C8, 32'h0000_0000, 32'hFFFF_FFD8,
                                 32'h0000_0064, 32'hFFFF_FF9C};

  ccr_top i_ccr_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vid_in(vid_in), .vid_in_valid(vid_in_valid), .vid_src(vid_src),
    .vid_bus(vid_bus), .vid_out(vid_out), .vid_out_valid(vid_out_valid));

  // Clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // One APB transfer, answer waited for under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 300);
    if (n >= 300) errors++;
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Exact comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Comparison within a tolerance
  task automatic near(input logic [9:0] got, input logic [9:0] exp, input int tol);
    int d;
    d = int'(got) - int'(exp);
    samples_checked++;
    if ((^got) === 1'bx || d > tol || d < -tol) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Frame-start pixel in, output exactly four edges later
  task automatic pix(input logic [3:0] s, input logic [9:0] y, input logic [9:0] cb,
                     input logic [9:0] cr, input logic [9:0] ey, input logic [9:0] ecb,
                     input logic [9:0] ecr, input int tol);
    @(posedge clk);
    vid_src      <= s;
    vid_in       <= '{sof: 1'b1, y: y, cb: cb, cr: cr};
    vid_in_valid <= 1'b1;
    @(posedge clk);
    vid_in_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(32'(vid_out_valid), 32'h0000_0000);
    @(posedge clk);
    #1 chk(32'({vid_out_valid, vid_out.sof}), 32'h0000_0003);
    near(vid_out.y, ey, tol);
    near(vid_out.cb, ecb, tol);
    near(vid_out.cr, ecr, tol);
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    #200000;
    errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    vid_in = '0;
    vid_in_valid = 1'b0;
    vid_src = 4'h0;
    vid_bus = 2'h0;
    repeat (19) @(posedge clk);
    #1 chk(32'({pready, pslverr, vid_out_valid}), 32'h0000_0000);
    @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_0064);
    apb(1'b0, ccr_pkg::CCR_REG_LIFT, 32'h0); chk(rd, 32'h0000_0000);
    apb(1'b0, ccr_pkg::CCR_REG_GAMMA, 32'h0); chk(rd, 32'h0000_0000);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, t_a[i], t_w[i]);
      apb(1'b0, t_a[i], 32'h0); chk(rd, t_e[i]);
    end
    apb(1'b0, 8'h20, 32'h0); chk(32'(er), 32'h0000_0001);
    apb(1'b1, 8'h02, 32'h0); chk(32'(er), 32'h0000_0001);
    // Red linked to green, then reselect
    apb(1'b1, ccr_pkg::CCR_REG_CMD, 32'h0000_0001);
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_0008);
    apb(1'b1, ccr_pkg::CCR_REG_GAIN, 32'h0000_0096);
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_0001);
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_0096);
    apb(1'b1, ccr_pkg::CCR_REG_GAIN, 32'h0000_0032);
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_0000);
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_0096);
    // Red linked to blue, nominal restore
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_0010);
    apb(1'b1, ccr_pkg::CCR_REG_GAMMA, 32'h0000_0020);
    apb(1'b1, ccr_pkg::CCR_REG_CMD, 32'h0000_0001);
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_0064);
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_0002);
    apb(1'b0, ccr_pkg::CCR_REG_GAMMA, 32'h0); chk(rd, 32'h0000_0000);
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_0001);
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_0032);
    // All three linked from red
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_0000);
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_001C);
    apb(1'b1, ccr_pkg::CCR_REG_CMD, 32'h0000_0001);
    pix(4'h0, 10'h200, 10'h180, 10'h280, 10'h200, 10'h180, 10'h280, 6);
    apb(1'b1, ccr_pkg::CCR_REG_ENABLE, 32'h0000_0007);
    apb(1'b1, ccr_pkg::CCR_REG_GAIN, 32'h0000_0000);
    pix(4'h0, 10'h300, 10'h180, 10'h280, 10'h040, 10'h200, 10'h200, 8);
    pix(4'h0, 10'h100, 10'h250, 10'h1B0, 10'h040, 10'h200, 10'h200, 8);
    pix(4'h1, 10'h200, 10'h180, 10'h280, 10'h200, 10'h180, 10'h280, 6);
    apb(1'b0, ccr_pkg::CCR_REG_STATUS, 32'h0); chk(rd, 32'h0000_0002);
    // Edit another set, then come back to set zero
    apb(1'b1, ccr_pkg::CCR_REG_SET, 32'h0000_0001);
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_0064);
    apb(1'b1, ccr_pkg::CCR_REG_SET, 32'h0000_0000);
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_0000);
    apb(1'b1, ccr_pkg::CCR_REG_GAIN, 32'h0000_00C8);
    apb(1'b1, ccr_pkg::CCR_REG_LIFT, 32'h0000_0064);
    pix(4'h0, 10'h3AC, 10'h200, 10'h200, 10'h3FF, 10'h200, 10'h200, 32);
    apb(1'b1, ccr_pkg::CCR_REG_GAIN, 32'h0000_0064);
    apb(1'b1, ccr_pkg::CCR_REG_LIFT, 32'h0000_0028);
    pix(4'h0, 10'h100, 10'h200, 10'h200, 10'h25E, 10'h200, 10'h200, 10);
    apb(1'b1, ccr_pkg::CCR_REG_LIFT, 32'h0000_0000);
    apb(1'b1, ccr_pkg::CCR_REG_GAMMA, 32'h0000_0064);
    pix(4'h0, 10'h200, 10'h200, 10'h200, 10'h300, 10'h200, 10'h200, 12);
    apb(1'b1, ccr_pkg::CCR_REG_GAMMA, 32'h0000_FF9C);
    pix(4'h0, 10'h200, 10'h200, 10'h200, 10'h100, 10'h200, 10'h200, 12);
    apb(1'b1, ccr_pkg::CCR_REG_ENABLE, 32'h0000_0000);
    pix(4'h0, 10'h200, 10'h200, 10'h200, 10'h200, 10'h200, 10'h200, 6);
    apb(1'b0, ccr_pkg::CCR_REG_GAMMA, 32'h0); chk(rd, 32'hFFFF_FF9C);
    // Black endpoint write keeps white at nominal
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_002C);
    apb(1'b1, ccr_pkg::CCR_REG_LIFT, 32'h0000_0028);
    apb(1'b1, ccr_pkg::CCR_REG_CTRL, 32'h0000_000C);
    apb(1'b0, ccr_pkg::CCR_REG_GAIN, 32'h0); chk(rd, 32'h0000_003C);
    finish_test();
  end
endmodule
